// *** include/lalu_pkg.sv ***
// constants, types and decode helpers for the long add / logic execute slice
package lalu_pkg;

  // data and field widths
  localparam int unsigned LALU_XLEN      = 64;
  localparam int unsigned LALU_ILEN      = 32;
  localparam int unsigned LALU_IMM_W     = 16;
  localparam int unsigned LALU_PFX_W     = 48;
  localparam int unsigned LALU_REG_W     = 5;

  // field positions; the K and C bit positions count bit 0 as the instruction msb, the _LSB ones count from the lsb
  localparam int unsigned LALU_OPC_LSB   = 26;
  localparam int unsigned LALU_RD_LSB    = 21;
  localparam int unsigned LALU_SEL_LSB   = 16;
  localparam int unsigned LALU_FN_W      = 11;
  localparam int unsigned LALU_K_POS     = 3;
  localparam int unsigned LALU_C_POS     = 4;
  localparam int unsigned LALU_K_POS_ALT = 13;
  localparam int unsigned LALU_C_POS_ALT = 14;

  // encodings
  localparam logic [2:0]  LALU_OPC_ADD_R_HI = 3'h0;
  localparam logic [2:0]  LALU_OPC_ADD_I_HI = 3'h1;
  localparam logic [5:0]  LALU_OPC_AND_R    = 6'h21;
  localparam logic [5:0]  LALU_OPC_ANDN_R   = 6'h23;
  localparam logic [5:0]  LALU_OPC_AND_I    = 6'h29;
  localparam logic [5:0]  LALU_OPC_ANDN_I   = 6'h2b;
  localparam logic [5:0]  LALU_OPC_LIMM_GRP = 6'h1a;
  localparam logic [10:0] LALU_FN_LONG      = 11'h100;
  localparam logic [1:0]  LALU_SEL_ADD_HI   = 2'h0;
  localparam logic [4:0]  LALU_SEL_AND      = 5'h11;
  localparam logic [4:0]  LALU_SEL_ANDN     = 5'h13;

  // reset values and timing
  localparam logic        LALU_CARRY_RST    = 1'b0;
  localparam int unsigned LALU_LATENCY      = 1;

  // operation kind, one-hot
  typedef enum logic [2:0] {
    LALU_OP_ADD  = 3'b001,
    LALU_OP_AND  = 3'b010,
    LALU_OP_ANDN = 3'b100
  } lalu_op_type;

  // instruction bit by msb-first position
  function automatic logic lalu_ibit(input logic [LALU_ILEN-1:0] ins, input int unsigned pos);
    lalu_ibit = ins[LALU_ILEN-1-pos];
  endfunction

  // six-bit major opcode
  function automatic logic [5:0] lalu_opc(input logic [LALU_ILEN-1:0] ins);
    lalu_opc = ins[LALU_OPC_LSB +: 6];
  endfunction

endpackage

// *** include/lalu_op_if.sv ***
// operand and result carrier between the execute slice and its arithmetic core
`timescale 1ns/1ps
interface lalu_op_if;
  import lalu_pkg::*;
  logic [LALU_XLEN-1:0] opa;
  logic [LALU_XLEN-1:0] opb;
  logic                 cin;
  lalu_op_type          op;
  logic [LALU_XLEN-1:0] res;
  logic                 cout;

  modport ctl
  (
    output opa,
    output opb,
    output cin,
    output op,
    input  res,
    input  cout
  );

  modport core
  (
    input  opa,
    input  opb,
    input  cin,
    input  op,
    output res,
    output cout
  );
endinterface

// *** core/lalu_core.sv ***
// combinational 64-bit adder and and / and-not unit
`timescale 1ns/1ps
module lalu_core
  import lalu_pkg::*;
(
  lalu_op_if.core opif
);
  import lalu_pkg::*;

  logic [LALU_XLEN:0] sum_w;

  always_comb
  begin
    sum_w     = {1'b0, opif.opa} + {1'b0, opif.opb} + {{LALU_XLEN{1'b0}}, opif.cin};
    opif.cout = 1'b0;
    case (opif.op)
      LALU_OP_ADD:
      begin
        opif.res  = sum_w[LALU_XLEN-1:0];
        opif.cout = sum_w[LALU_XLEN];
      end
      LALU_OP_AND:  opif.res = opif.opa & opif.opb;
      LALU_OP_ANDN: opif.res = opif.opa & ~opif.opb;
      default:      opif.res = '0;
    endcase
  end
endmodule

// *** core/lalu_top.sv ***
// long add / and / and-not execute slice with the status carry flag
`timescale 1ns/1ps
module lalu_top
  import lalu_pkg::*;
(
  // clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // issue from decode
  input  wire logic                      iss_valid,
  input  wire logic [LALU_ILEN-1:0]      iss_instr,
  // operand values from the register file
  input  wire logic [LALU_XLEN-1:0]      ra_val,
  input  wire logic [LALU_XLEN-1:0]      rb_val,
  input  wire logic [LALU_XLEN-1:0]      rd_val,
  // long-immediate prefix
  input  wire logic                      pfx_valid,
  input  wire logic [LALU_PFX_W-1:0]     pfx_value,
  // direct write of the carry flag
  input  wire logic                      carry_wr,
  input  wire logic                      carry_wr_val,
  // write-back
  output logic                           wb_valid,
  output logic [LALU_REG_W-1:0]          wb_dest,
  output logic [LALU_XLEN-1:0]           wb_data,
  // status
  output logic                           status_carry_flag,
  output logic                           unknown_op,
  output logic                           missing_prefix
);
  import lalu_pkg::*;

  lalu_op_if opif ();

  // decode results
  logic [5:0]            opc;
  logic [4:0]            sel;
  logic [LALU_FN_W-1:0]  fn;
  logic [LALU_IMM_W-1:0] imm16;
  logic [LALU_XLEN-1:0]  imm64;
  logic                  grp;
  logic                  is_add_r;
  logic                  is_add_i;
  logic                  is_add_a;
  logic                  is_and_r;
  logic                  is_and_i;
  logic                  is_and_a;
  logic                  is_andn_r;
  logic                  is_andn_i;
  logic                  is_andn_a;
  logic                  is_add;
  logic                  is_imm;
  logic                  is_alt;
  logic                  known;
  logic                  hold_bit;
  logic                  cuse_bit;

  // registered state
  logic                  wb_valid_r;
  logic                  wb_valid_nxt;
  logic [LALU_REG_W-1:0] wb_dest_r;
  logic [LALU_REG_W-1:0] wb_dest_nxt;
  logic [LALU_XLEN-1:0]  wb_data_r;
  logic [LALU_XLEN-1:0]  wb_data_nxt;
  logic                  carry_r;
  logic                  carry_nxt;
  logic                  unknown_r;
  logic                  unknown_nxt;
  logic                  nopfx_r;
  logic                  nopfx_nxt;

  // instruction decode
  always_comb
  begin
    opc   = lalu_opc(iss_instr);
    sel   = iss_instr[LALU_SEL_LSB +: 5];
    fn    = iss_instr[LALU_FN_W-1:0];
    imm16 = iss_instr[LALU_IMM_W-1:0];
    grp   = (opc == LALU_OPC_LIMM_GRP);

    is_add_r  = (opc[5:3] == LALU_OPC_ADD_R_HI) && !opc[0] && (fn == LALU_FN_LONG);
    is_add_i  = (opc[5:3] == LALU_OPC_ADD_I_HI) && !opc[0];
    is_add_a  = grp && (sel[4:3] == LALU_SEL_ADD_HI) && !sel[0];
    // register and needs long function field
    is_and_r  = (opc == LALU_OPC_AND_R) && (fn == LALU_FN_LONG);
    is_and_i  = (opc == LALU_OPC_AND_I);
    is_and_a  = grp && (sel == LALU_SEL_AND);
    is_andn_r = (opc == LALU_OPC_ANDN_R) && (fn == LALU_FN_LONG);
    is_andn_i = (opc == LALU_OPC_ANDN_I);
    is_andn_a = grp && (sel == LALU_SEL_ANDN);

    is_add = is_add_r | is_add_i | is_add_a;
    is_alt = is_add_a | is_and_a | is_andn_a;
    is_imm = is_add_i | is_and_i | is_andn_i | is_alt;
    known  = is_add | is_and_r | is_and_i | is_and_a | is_andn_r | is_andn_i | is_andn_a;

    // hold and carry-use bit positions per form
    if (is_add_a)
    begin
      hold_bit = lalu_ibit(iss_instr, LALU_K_POS_ALT);
      cuse_bit = lalu_ibit(iss_instr, LALU_C_POS_ALT);
    end
    else
    begin
      hold_bit = lalu_ibit(iss_instr, LALU_K_POS);
      cuse_bit = lalu_ibit(iss_instr, LALU_C_POS);
    end

    // prefix widens the immediate, otherwise sign extension
    if (pfx_valid)
      imm64 = {pfx_value, imm16};
    else
      imm64 = {{(LALU_XLEN-LALU_IMM_W){imm16[LALU_IMM_W-1]}}, imm16};
  end

  // operand steering into the arithmetic core
  always_comb
  begin
    // alternate forms read the destination as source
    opif.opa = is_alt ? rd_val : ra_val;
    // complement applied in the core to the widened immediate
    opif.opb = is_imm ? imm64 : rb_val;
    // carry in only when carry-use is set
    opif.cin = is_add && cuse_bit && carry_r;
    if (is_add)
      opif.op = LALU_OP_ADD;
    else if (is_and_r | is_and_i | is_and_a)
      opif.op = LALU_OP_AND;
    else
      opif.op = LALU_OP_ANDN;
  end

  lalu_core u_core
  (
    .opif (opif.core)
  );

  // next state of result and flags
  always_comb
  begin
    wb_valid_nxt = wb_valid_r;
    wb_dest_nxt  = wb_dest_r;
    wb_data_nxt  = wb_data_r;
    carry_nxt    = carry_r;
    unknown_nxt  = unknown_r;
    nopfx_nxt    = nopfx_r;
    if (clk_en)
    begin
      if (carry_wr)
        carry_nxt = carry_wr_val;
      // result registered one cycle after issue
      wb_valid_nxt = iss_valid && known;
      unknown_nxt  = iss_valid && !known;
      // three-operand immediate forms rely on a prefix
      nopfx_nxt    = iss_valid && (is_add_i | is_and_i | is_andn_i) && !pfx_valid;
      if (iss_valid && known)
      begin
        wb_dest_nxt = iss_instr[LALU_RD_LSB +: LALU_REG_W];
        wb_data_nxt = opif.res;
        if (is_add && !hold_bit)
          carry_nxt = opif.cout;
        else if (is_add && hold_bit)
          carry_nxt = carry_wr ? carry_wr_val : carry_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_valid_r <= 1'b0;
      wb_dest_r  <= '0;
      wb_data_r  <= '0;
      carry_r    <= LALU_CARRY_RST;
      unknown_r  <= 1'b0;
      nopfx_r    <= 1'b0;
    end
    else
    begin
      wb_valid_r <= wb_valid_nxt;
      wb_dest_r  <= wb_dest_nxt;
      wb_data_r  <= wb_data_nxt;
      carry_r    <= carry_nxt;
      unknown_r  <= unknown_nxt;
      nopfx_r    <= nopfx_nxt;
    end
  end

  // outputs straight from flip-flops
  assign wb_valid          = wb_valid_r;
  assign wb_dest           = wb_dest_r;
  assign wb_data           = wb_data_r;
  assign status_carry_flag = carry_r;
  assign unknown_op        = unknown_r;
  assign missing_prefix    = nopfx_r;

endmodule

// *** dv/lalu_sva.sv ***
// port assertions for the long add / logic slice
`timescale 1ns/1ps
module lalu_sva
(
  // control
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        iss_valid,
  input wire logic        pfx_valid,
  input wire logic        carry_wr,
  // operands
  input wire logic [31:0] iss_instr,
  input wire logic [63:0] ra_val,
  input wire logic [63:0] rb_val,
  input wire logic [63:0] rd_val,
  input wire logic [47:0] pfx_value,
  // results
  input wire logic        wb_valid,
  input wire logic [63:0] wb_data,
  input wire logic        status_carry_flag,
  input wire logic        unknown_op
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire        go  = iss_valid && clk_en;
  wire [5:0]  opc = iss_instr[31:26];
  wire        fn  = iss_instr[10:0] == 11'h100;
  wire [63:0] imm = {pfx_value, iss_instr[15:0]};
  wire [64:0] sum = {1'b0, ra_val} + {1'b0, rb_val};
  a_one_answer: assert property (go |=> wb_valid ^ unknown_op)
    else $error("issue without single answer");
  a_sum_reg: assert property (go && opc == 6'h00 && fn |=> wb_data == $past(sum[63:0]))
    else $error("register add sum wrong");
  a_carry_load: assert property (go && opc == 6'h00 && fn |-> ##1 status_carry_flag == $past(sum[64]))
    else $error("carry out not loaded");
  a_carry_hold: assert property (go && opc == 6'h04 && fn && !carry_wr |=> $stable(status_carry_flag))
    else $error("held carry changed");
  a_carry_in: assert property (go && opc == 6'h02 && fn |=> wb_data == $past(ra_val + rb_val + status_carry_flag))
    else $error("carry in not added");
  a_imm_add: assert property (go && opc == 6'h08 && pfx_valid |=> wb_data == $past(ra_val + imm))
    else $error("immediate add wrong");
  a_and_reg: assert property (go && opc == 6'h21 && fn |=> wb_data == $past(ra_val & rb_val))
    else $error("register and wrong");
  a_andn_reg: assert property (go && opc == 6'h23 && fn |=> wb_data == $past(ra_val & ~rb_val))
    else $error("register and-not wrong");
  a_and_imm: assert property (go && opc == 6'h29 && pfx_valid |=> wb_data == $past(ra_val & imm))
    else $error("and immediate wrong");
  a_andn_alt: assert property (go && opc == 6'h1a && iss_instr[20:16] == 5'h13 && pfx_valid
    |=> wb_data == $past(rd_val & ~imm))
    else $error("selector and-not wrong");
endmodule
bind lalu_top lalu_sva u_sva (.*);

// *** dv/lalu_rf_model.sv ***
// register file standing in for decode and write-back
`timescale 1ns/1ps
module lalu_rf_model
(
  // instruction and write-back
  input  wire logic        ref_clk,
  input  wire logic [31:0] iss_instr,
  input  wire logic        wb_valid,
  input  wire logic [4:0]  wb_dest,
  input  wire logic [63:0] wb_data,
  // operand values
  output logic      [63:0] ra_val,
  output logic      [63:0] rb_val,
  output logic      [63:0] rd_val
);
  logic [63:0] regs [32];
  initial
  begin
    for (int k = 0; k < 32; k++)
      regs[k] = ~(64'h0123456789abcdef * k);
  end
  assign ra_val = regs[iss_instr[20:16]];
  assign rb_val = regs[iss_instr[15:11]];
  assign rd_val = regs[iss_instr[25:21]];
  always @(posedge ref_clk)
  begin
    if (wb_valid)
      regs[wb_dest] <= wb_data;
  end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the long add / logic slice
`timescale 1ns/1ps
module testbench;
  import lalu_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, iss_valid = 1'b0;
  logic [31:0] iss_instr = 32'h0;
  logic        pfx_valid = 1'b0, carry_wr = 1'b0, carry_wr_val = 1'b0;
  logic [47:0] pfx_value = 48'h0;
  logic [63:0] ra_val, rb_val, rd_val, wb_data, e_d;
  logic [4:0]  wb_dest, e_r;
  logic        wb_valid, status_carry_flag, unknown_op, missing_prefix;
  logic        e_v, e_u, e_m, e_c, pend;
  logic [65:0] p;
  logic [31:0] i, r;
  logic [5:0]  opcs [8] = '{6'h00, 6'h0e, 6'h1a, 6'h21, 6'h23, 6'h29, 6'h2b, 6'h3f};
  integer      mismatches = 0;
  integer      n_tests = 0;
  integer      seed = 11934;
  lalu_top      uut (.*);
  lalu_rf_model rf (.*);
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // {unknown, next carry, result} of what is on the issue port
  function automatic logic [65:0] predict();
    logic [5:0]  o;
    logic [63:0] im, a, s;
    logic        k, cu, ad, u, co, f;
    o  = iss_instr[31:26];
    f  = iss_instr[10:0] == 11'h100;
    im = pfx_valid ? {pfx_value, iss_instr[15:0]} : 64'($signed(iss_instr[15:0]));
    {k, cu, a, s, ad, u, co} = {iss_instr[28:27], ra_val, im, 3'b100};
    if (o[5:3] == 3'h0 && !o[0] && f)
      s = rb_val;
    else if (o == 6'h1a && iss_instr[20:19] == 2'h0 && !iss_instr[16])
      {k, cu, a} = {iss_instr[18:17], rd_val};
    else if (o[5:3] != 3'h1 || o[0])
    begin
      ad = 1'b0;
      if (o == 6'h1a)
        a = rd_val;
      if (o == 6'h21 || o == 6'h23)
        im = rb_val;
      if (o == 6'h21 && f || o == 6'h29 || o == 6'h1a && iss_instr[20:16] == 5'h11)
        s = a & im;
      else if (o == 6'h23 && f || o == 6'h2b || o == 6'h1a && iss_instr[20:16] == 5'h13)
        s = a & ~im;
      else
        u = 1'b1;
    end
    ad = ad && iss_valid;
    if (ad)
      {co, s} = {1'b0, a} + {1'b0, s} + 65'(cu & e_c);
    predict = {u, ad && !k ? co : (carry_wr ? carry_wr_val : e_c), s};
  endfunction
  task automatic step(input logic v, input logic [31:0] ins, input logic pv, input logic ce);
    @(posedge ref_clk);
    iss_valid    <= v;
    iss_instr    <= ins;
    pfx_valid    <= pv;
    pfx_value    <= 48'({$random(seed), $random(seed)});
    carry_wr     <= ($random(seed) & 7) == 0;
    carry_wr_val <= 1'($random(seed));
    clk_en       <= ce;
    #1;
    if (pend)
    begin
      chk("wb_valid", e_v, wb_valid);
      chk("unknown_op", e_u, unknown_op);
      chk("missing_prefix", e_m, missing_prefix);
      chk("carry", e_c, status_carry_flag);
      if (e_v)
      begin
        chk("wb_data", e_d, wb_data);
        chk("wb_dest", e_r, wb_dest);
      end
    end
    p    = predict();
    pend = 1'b1;
    // enable low: every output holds
    if (ce)
    begin
      e_v = v && !p[65];
      e_u = v && p[65];
      e_m = v && !pv && (ins[31:29] == 3'h1 && !ins[26] || ins[31:26] == 6'h29 || ins[31:26] == 6'h2b);
      e_c = p[64];
      e_r = ins[25:21];
      e_d = p[63:0];
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    summarize();
  end
  initial
  begin
    pend = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    {pend, e_v, e_u, e_m, e_c} = 5'h10;
    for (int kc = 0; kc < 4; kc++)
    begin
      step(1'b1, {3'h0, 2'(kc), 1'b0, 5'h4, 5'h0, 5'h1, 11'h100}, 1'b0, 1'b1);
      step(1'b1, {3'h1, 2'(kc), 1'b0, 5'h5, 5'h0, 16'h8001}, 1'(~kc), 1'b1);
      step(1'b1, {6'h1a, 5'h6, 2'h0, 2'(kc), 1'b0, 16'hffff}, 1'b0, 1'b1);
    end
    for (int n = 0; n < 400; n++)
    begin
      i = $random(seed);
      r = $random(seed);
      i[31:26] = opcs[r[2:0]];
      if (!r[3])
        i[10:0] = 11'h100;
      if (r[4])
        i[20:16] = r[5] ? 5'h11 : 5'h13;
      step(r[6] | r[7], i, r[8], r[9] | r[10] | r[11]);
    end
    step(1'b0, 32'h0, 1'b0, 1'b1);
    summarize();
  end
endmodule
